/* sacr_pkg.sv */
// package for the sar converter conversion and serial readout block
// assumes a 125 MHz sys_clk; shared by the design file and the bench
package sacr_pkg;
    // ==========================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int ACQ_START_NS = 527;      // acquisition restarts after conversion start
    localparam int CONV_MAX_NS = 3000;      // longest conversion time
    localparam int ACQ_START_CYC = (ACQ_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    // ==========================================
    // result word
    localparam int RES_W = 18;
    localparam logic [17:0] RES_RESET = 18'h00000;
    // ==========================================
    // power state
    typedef enum logic [1:0] {
        SACR_NAP,
        SACR_CONVERT,
        SACR_SLEEP
    } sacr_state_t;
endpackage

/* sacr_core.sv */
// sacr_core: conversion sequencer, nap and sleep control, serial result readout
// assumes convert_start, shift clock, read_enable_or_serial_in and chain_select are
// asynchronous pins; conversion result arrives as a parallel word from the analog core
//
// Overview of operation
// - convert_start rising edge starts conversion and powers up the core.
// - convert_start edges during a conversion do not restart it; a second one with no shift rise between requests sleep.
// - busy is high for the whole conversion, low when it ends.
// - acquisition of next sample begins 527ns after conversion start.
// - internal counter bounds conversion to at most 3 microseconds.
// - after conversion the core naps until next convert_start rising edge.
// - result can be shifted out during nap.
// - after sleep request, sleep begins at falling busy of last conversion.
// - shift clock rising edge wakes the device from sleep.
// - serial output updates on each rising shift clock edge when enabled.
// - result msb holds on serial output until first rising shift edge.
// - normal mode: output enabled when read enable is low, off when high.
// - normal mode, read enable low: fresh msb appears at busy fall.
// - lowering read enable presents the result msb immediately.
// - chain mode: output always enabled, read enable pin is serial input.
// - chain mode: upstream msb reaches output after 18 shift cycles.
// - chain mode captures upstream bit on each rising shift edge.
`timescale 1ns/10ps
module sacr_core #(
    parameter int RES_W = sacr_pkg::RES_W
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic convert_start,
    input wire logic shift_clk,
    input wire logic read_enable_or_serial_in,
    input wire logic chain_select,
    input wire logic [RES_W-1:0] core_result,
    output logic busy,
    output logic acquire,
    output logic core_power_on,
    output logic asleep,
    output logic serial_out_o,
    output logic serial_out_oe
);
    // ==========================================
    // pin synchronisers
    logic [1:0] cnv_sync_q, sck_sync_q, rdl_sync_q, chn_sync_q;
    logic cnv_prev_q, sck_prev_q, rdl_prev_q;
    // read enable resets high so the output starts released
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnv_sync_q <= 2'h0;
            sck_sync_q <= 2'h0;
            rdl_sync_q <= 2'h3;
            chn_sync_q <= 2'h0;
            cnv_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
            rdl_prev_q <= 1'b1;
        end else begin
            cnv_sync_q <= {cnv_sync_q[0], convert_start};
            sck_sync_q <= {sck_sync_q[0], shift_clk};
            rdl_sync_q <= {rdl_sync_q[0], read_enable_or_serial_in};
            chn_sync_q <= {chn_sync_q[0], chain_select};
            cnv_prev_q <= cnv_sync_q[1];
            sck_prev_q <= sck_sync_q[1];
            rdl_prev_q <= rdl_sync_q[1];
        end
    end
    // edge detectors compare the second stage with its last value
    logic cnv_rise, sck_rise, rdl_fall, chain_mode, rdl_lvl;
    assign cnv_rise = cnv_sync_q[1] & ~cnv_prev_q;
    assign sck_rise = sck_sync_q[1] & ~sck_prev_q;
    assign rdl_fall = ~rdl_sync_q[1] & rdl_prev_q;
    assign chain_mode = chn_sync_q[1];
    assign rdl_lvl = rdl_sync_q[1];

    // ==========================================
    // conversion sequencer
    sacr_pkg::sacr_state_t state_q;
    logic [sacr_pkg::CNT_W-1:0] conv_cnt_q;
    logic conv_done, start_ok;
    assign conv_done = (state_q == sacr_pkg::SACR_CONVERT) &&
                       (conv_cnt_q == sacr_pkg::CNT_W'(sacr_pkg::CONV_CYC - 1));
    // count runs from zero to the end count, then the state leaves
    // starts only outside a conversion
    assign start_ok = cnv_rise && (state_q != sacr_pkg::SACR_CONVERT);
    // ==========================================
    // sleep request pairing
    // sleep request: second convert start with no shift rise between
    logic pend_q, sleep_req_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pend_q <= 1'b0;
        end else if (cnv_rise) begin
            pend_q <= 1'b1;
        end else if (sck_rise) begin
            pend_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sleep_req_q <= 1'b0;
        end else if (cnv_rise && pend_q && !sck_rise) begin
            sleep_req_q <= 1'b1;
        end else if (sck_rise) begin
            sleep_req_q <= 1'b0;
        end
    end
    // rising start powers up and converts
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= sacr_pkg::SACR_NAP;
            conv_cnt_q <= '0;
        end else begin
            case (state_q)
                sacr_pkg::SACR_NAP: begin
                    conv_cnt_q <= '0;
                    if (start_ok) begin
                        state_q <= sacr_pkg::SACR_CONVERT;
                    end
                end
                sacr_pkg::SACR_CONVERT: begin
                    conv_cnt_q <= conv_cnt_q + 1'b1;
                    if (conv_done) begin
                        // sleep at busy fall after request
                        state_q <= (sleep_req_q || (cnv_rise && pend_q && !sck_rise)) ?
                                   sacr_pkg::SACR_SLEEP : sacr_pkg::SACR_NAP;
                    end
                end
                sacr_pkg::SACR_SLEEP: begin
                    conv_cnt_q <= '0;
                    if (sck_rise) begin
                        state_q <= sacr_pkg::SACR_NAP;
                    end
                end
                default: begin
                    state_q <= sacr_pkg::SACR_NAP;
                    conv_cnt_q <= '0;
                end
            endcase
        end
    end
    assign busy = (state_q == sacr_pkg::SACR_CONVERT);
    assign core_power_on = (state_q == sacr_pkg::SACR_CONVERT);
    assign asleep = (state_q == sacr_pkg::SACR_SLEEP);
    assign acquire = (state_q != sacr_pkg::SACR_CONVERT) ||
                     (conv_cnt_q >= sacr_pkg::CNT_W'(sacr_pkg::ACQ_START_CYC));

    // ==========================================
    // serial readout shift path
    // a load at the end count wins over a shift edge in that cycle
    logic [RES_W-1:0] shift_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            shift_q <= sacr_pkg::RES_RESET;
        end else if (conv_done) begin
            // fresh msb loaded at busy fall
            shift_q <= core_result;
        end else if (sck_rise && state_q != sacr_pkg::SACR_SLEEP &&
                     (chain_mode || !rdl_lvl)) begin
            // shift on rising edge while enabled
            // msb first, one bit per edge
            // chain mode pulls upstream bit in
            shift_q <= {shift_q[RES_W-2:0], chain_mode ? rdl_lvl : 1'b0};
        end
    end
    // msb holds until first shift edge
    // output tracks register, so msb shows as soon as enabled
    assign serial_out_o = shift_q[RES_W-1];
    // enable is combinational so selection reaches the pin at once
    // normal mode enable from read enable
    assign serial_out_oe = chain_mode | ~rdl_lvl;

    // ==========================================
    // assertions
    sequence start_seen_s;
        start_ok;
    endsequence
    sequence busy_run_s;
        busy [*8];
    endsequence
    conv_start_a: assert property (@(posedge sys_clk) disable iff (srst)
        start_ok |=> busy) else $error("start did not raise busy");
    no_restart_a: assert property (@(posedge sys_clk) disable iff (srst)
        (busy && cnv_rise && !conv_done) |=> busy && conv_cnt_q == $past(conv_cnt_q) + 1'b1)
        else $error("conversion restarted");
    busy_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        start_seen_s |=> busy_run_s) else $error("busy dropped early");
    conv_len_a: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(busy) |-> ##[374:375] !busy) else $error("conversion length wrong");
    acq_time_a: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(busy) |-> !acquire [*8]) else $error("acquire too early");
    nap_after_a: assert property (@(posedge sys_clk) disable iff (srst)
        (conv_done && !sleep_req_q && !(cnv_rise && pend_q)) |=> state_q == sacr_pkg::SACR_NAP)
        else $error("no nap after conversion");
    sleep_entry_a: assert property (@(posedge sys_clk) disable iff (srst)
        (conv_done && sleep_req_q) |=> asleep) else $error("sleep not entered");
    wake_up_a: assert property (@(posedge sys_clk) disable iff (srst)
        (asleep && sck_rise) |=> !asleep) else $error("no wake on shift edge");
    msb_load_a: assert property (@(posedge sys_clk) disable iff (srst)
        conv_done |=> serial_out_o == $past(core_result[RES_W-1])) else $error("msb not loaded");
    out_enable_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!chain_mode && rdl_lvl) |-> !serial_out_oe) else $error("output driven while disabled");
    chain_oe_a: assert property (@(posedge sys_clk) disable iff (srst)
        chain_mode |-> serial_out_oe) else $error("chain output not enabled");
    shift_step_a: assert property (@(posedge sys_clk) disable iff (srst)
        (sck_rise && !conv_done && !asleep && serial_out_oe) |=>
        serial_out_o == $past(shift_q[RES_W-2])) else $error("shift did not advance");
    chain_in_a: assert property (@(posedge sys_clk) disable iff (srst)
        (sck_rise && chain_mode && !conv_done && !asleep) |=> shift_q[0] == $past(rdl_lvl))
        else $error("chain input not captured");
    msb_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!sck_rise && !conv_done) |=> $stable(serial_out_o)) else $error("msb changed without edge");
    idle_busy_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!busy && !start_ok) |=> !busy) else $error("busy rose without start");
    // ==========================================
    // assertions: power states and sleep pairing
    sequence pair_seen_s;
        cnv_rise && pend_q && !sck_rise;
    endsequence
    sequence wake_seen_s;
        asleep && sck_rise;
    endsequence
    // second pulse arms the request
    sleep_arm_a: assert property (@(posedge sys_clk) disable iff (srst)
        pair_seen_s |=> sleep_req_q) else $error("sleep request not armed");
    // shift edge cancels the pairing
    sleep_cancel_a: assert property (@(posedge sys_clk) disable iff (srst)
        (sck_rise && !cnv_rise) |=> !pend_q && !sleep_req_q) else $error("pairing not cancelled");
    // pair landing on the end count still sleeps
    sleep_late_a: assert property (@(posedge sys_clk) disable iff (srst)
        (conv_done && cnv_rise && pend_q && !sck_rise) |=> asleep) else $error("late pair missed sleep");
    // sleep holds until a shift edge
    sleep_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        (asleep && !sck_rise) |=> asleep) else $error("sleep left without shift edge");
    sleep_power_a: assert property (@(posedge sys_clk) disable iff (srst)
        asleep |-> !busy && !core_power_on) else $error("busy or core on in sleep");
    // wake lands in nap
    wake_nap_a: assert property (@(posedge sys_clk) disable iff (srst)
        wake_seen_s |=> state_q == sacr_pkg::SACR_NAP) else $error("wake did not reach nap");
    // waking edge moves no data
    wake_noshift_a: assert property (@(posedge sys_clk) disable iff (srst)
        wake_seen_s |=> $stable(shift_q)) else $error("waking edge shifted data");
    // nap holds until a start edge
    nap_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        (state_q == sacr_pkg::SACR_NAP && !start_ok) |=> state_q == sacr_pkg::SACR_NAP)
        else $error("nap left without start");
    // core powered only while converting
    core_power_a: assert property (@(posedge sys_clk) disable iff (srst)
        busy |-> core_power_on) else $error("core not powered in conversion");
    nap_power_a: assert property (@(posedge sys_clk) disable iff (srst)
        !busy |-> !core_power_on) else $error("core powered outside conversion");
    // busy edges only at accepted start and end count
    busy_rise_a: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(busy) |-> $past(start_ok)) else $error("busy rose without accepted start");
    busy_fall_a: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(busy) |-> $past(conv_done)) else $error("busy fell before end count");
    // conversion count stays inside its span
    conv_cap_a: assert property (@(posedge sys_clk) disable iff (srst)
        busy |-> conv_cnt_q < sacr_pkg::CNT_W'(sacr_pkg::CONV_CYC)) else $error("conversion count overran");
    cnt_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
        !busy |=> conv_cnt_q == '0) else $error("conversion count not cleared");
    // acquisition window
    acq_open_a: assert property (@(posedge sys_clk) disable iff (srst)
        (busy && conv_cnt_q >= sacr_pkg::CNT_W'(sacr_pkg::ACQ_START_CYC)) |-> acquire)
        else $error("acquire closed late in conversion");
    acq_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
        !busy |-> acquire) else $error("acquire closed outside conversion");
    // ==========================================
    // assertions: readout word
    load_word_a: assert property (@(posedge sys_clk) disable iff (srst)
        conv_done |=> shift_q == $past(core_result)) else $error("result word not loaded");
    zero_fill_a: assert property (@(posedge sys_clk) disable iff (srst)
        (sck_rise && !chain_mode && !rdl_lvl && !conv_done && !asleep) |=> !shift_q[0])
        else $error("normal shift did not fill zero");
    idle_noshift_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!chain_mode && rdl_lvl && !conv_done) |=> $stable(shift_q)) else $error("disabled output shifted");
    oe_normal_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!chain_mode && !rdl_lvl) |-> serial_out_oe) else $error("selected output not driven");
    // selection shows the stored msb at once
    sel_msb_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!chain_mode && rdl_fall) |-> serial_out_oe && serial_out_o == shift_q[RES_W-1])
        else $error("msb not shown on selection");
    shift_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
        (!sck_rise && !conv_done) |=> $stable(shift_q)) else $error("data moved without shift edge");
    // whole word moves one place per chain edge
    chain_path_a: assert property (@(posedge sys_clk) disable iff (srst)
        (sck_rise && chain_mode && !conv_done && !asleep) |=> shift_q[RES_W-1:1] == $past(shift_q[RES_W-2:0]))
        else $error("chain path did not advance");
endmodule

/* sacr_host.sv */
// host model: convert start, shift clock, read enable or upstream serial data
// assumes the bench sys_clk; every pin moves on its falling edge
`timescale 1ns/10ps
module sacr_host #(parameter int SCK_HALF = 5) (
    input wire logic sys_clk,
    input wire logic sdo_line,
    output logic convert_start,
    output logic shift_clk,
    output logic read_enable_or_serial_in
);
    // ========================================
    // idle levels, read enable high
    initial begin
        convert_start = 1'b0;
        shift_clk = 1'b0;
        read_enable_or_serial_in = 1'b1;
    end
    // second rise 16 ns after the first
    task automatic convert(input int pulses);
        repeat (2 * pulses) @(negedge sys_clk) convert_start = ~convert_start;
    endtask
    task automatic sel(input logic v);
        @(negedge sys_clk) read_enable_or_serial_in = v; // normal mode enable level
    endtask
    // sample before each rise; 80 ns period; upstream bit leads the rise
    task automatic shift18(input bit chain, input logic [17:0] up, output logic [17:0] got);
        for (int i = 17; i >= 0; i--) begin
            got[i] = sdo_line;
            if (chain) read_enable_or_serial_in = up[i];
            @(negedge sys_clk) shift_clk = 1'b1;
            repeat (SCK_HALF) @(negedge sys_clk);
            shift_clk = 1'b0;
            repeat (SCK_HALF - 1) @(negedge sys_clk);
        end
        if (chain) read_enable_or_serial_in = ~read_enable_or_serial_in; // released line flips
    endtask
endmodule

/* tb_top.sv */
// self-checking bench: conversion timing, nap and sleep, normal and chain readout
// assumes sacr_pkg, sacr_core and sacr_host are compiled before it
`timescale 1ns/10ps
module tb_top;
    logic sys_clk = 1'b0, srst = 1'b1, chain_select = 1'b0;
    logic convert_start, shift_clk, read_enable_or_serial_in, sdo_line;
    logic busy, acquire, core_power_on, asleep, serial_out_o, serial_out_oe;
    logic [17:0] core_result = 18'h00000, got;
    int num_errors = 0, n_tests = 0;
    localparam int POR_WAIT_CYC = 200000 / sacr_pkg::CLK_PERIOD_NS; // quiet span after power-on
    localparam int WAKE_CYC = 16; // wake settle span, plain default
    // ========================================
    // 125 MHz clock
    initial forever #4 sys_clk = ~sys_clk;
    // released output shows the inverse of held data; converter and host
    assign sdo_line = serial_out_oe ? serial_out_o : ~serial_out_o;
    sacr_core u_dut (.sys_clk, .srst, .convert_start, .shift_clk, .read_enable_or_serial_in, .chain_select,
        .core_result, .busy, .acquire, .core_power_on, .asleep, .serial_out_o, .serial_out_oe);
    sacr_host u_host (.sys_clk, .sdo_line, .convert_start, .shift_clk, .read_enable_or_serial_in);
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one conversion; offsets count from the first start rise through the pin sync
    task automatic do_conv(input int pulses, input logic [17:0] res);
        core_result = res;
        u_host.convert(pulses);
        repeat (6 - 2 * pulses) @(negedge sys_clk);
        check(18'({busy, core_power_on}), 18'h3);
        repeat (sacr_pkg::ACQ_START_CYC - 4) @(negedge sys_clk);
        check(18'(acquire), 18'h0);
        repeat (5) @(negedge sys_clk);
        check(18'(acquire), 18'h1);
        repeat (sacr_pkg::CONV_CYC - 70) @(negedge sys_clk);
        check(18'(busy), 18'h1);
        repeat (4) @(negedge sys_clk);
        check(18'({busy, core_power_on}), 18'h0);
    endtask
    // normal reads, enable gating, sleep and wake, chain mode
    initial begin
        repeat (3) @(negedge sys_clk);
        srst = 1'b0;
        check(18'({busy, serial_out_oe}), 18'h0);
        repeat (POR_WAIT_CYC) @(negedge sys_clk); // no start before re-initialisation ends
        u_host.sel(1'b0);
        do_conv(1, 18'h2d5a3);
        check(18'(sdo_line), 18'h1);
        u_host.shift18(1'b0, 18'h00000, got);
        check(got, 18'h2d5a3);
        u_host.sel(1'b1);
        do_conv(1, 18'h3a5c6);
        check(18'(serial_out_oe), 18'h0);
        u_host.sel(1'b0);
        repeat (4) @(negedge sys_clk);
        check(18'({serial_out_oe, serial_out_o}), 18'h3);
        do_conv(2, 18'h15555);
        check(18'({asleep, busy, core_power_on}), 18'h4);
        u_host.shift18(1'b0, 18'h00000, got);
        check(18'(asleep), 18'h0);
        repeat (WAKE_CYC) @(negedge sys_clk); // settle after wake
        u_host.sel(1'b1);
        chain_select = 1'b1;
        do_conv(1, 18'h2b3c4);
        check(18'(serial_out_oe), 18'h1);
        u_host.shift18(1'b1, 18'h1f0e1, got);
        check(got, 18'h2b3c4);
        u_host.shift18(1'b1, 18'h00000, got);
        check(got, 18'h1f0e1);
        finish_test();
    end
    // watchdog well past the expected run of some 220 us
    initial begin
        #300000;
        num_errors++;
        finish_test();
    end
endmodule
